// [ssl_layout.sv]
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Extended region of every save area begins at byte 576 from base.
// - Components two and up live in the extended region; zero and one in legacy.
// - Bitmap bit 63 selects standard (clear) or compacted (set) extended format.
// - Standard format places each component at its enumerated offset and size.
// - Compacted format: a component with bitmap bit zero takes no space.
// - Compacted format: first present component among bits 62:2 sits at 576.
// - Each further present component follows the previous present one plus its size.
// - Control word bytes 1:0, status word 3:2, last opcode 7:6.
// - Save writes byte 4 as abridged tag: bit j zero when register j empty.
// - Restore marks register empty (11B) when bit clear, else derives tag from value.
// - No 64-bit prefix: IP offset 11:8, selector 13:12, zeroed/ignored if deprecated.
// - With 64-bit prefix: bytes 15:8 hold full 64-bit instruction pointer.
// - No 64-bit prefix: data offset 19:16, selector 21:20, same deprecation handling.
// - With 64-bit prefix: bytes 23:16 hold full 64-bit data pointer.
// - Stack registers in bytes 159:32, 128-bit slots, value in low 80 bits.
// - Vector control/status in 27:24; reserved bits set on restore give protection fault.
// - Valid-bit mask held in bytes 31:28 and ignored on restore.
// - Vector regs 0-7 at 287:160, 8-15 at 415:288, upper only in 64-bit mode.
// - Component 2 reports standard offset 576 and size 256 bytes.
// - Component 2: bytes 127:0 regs 0-7, 255:128 regs 8-15 only in 64-bit mode.
// - Components need save feature enable; comp 1 needs bit 1; comp 2 bits 1 and 2.
// - Enable bit 0 always 1; writing bit 2 set with bit 1 clear faults.
// - Base is 64-byte aligned; 512-byte legacy region then 64-byte header at 512.
module ssl_layout (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Avalon-MM register slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Line master toward the save area
	output logic [ssl_pkg::ADDR_W-1:0] mem_address,
	output logic mem_write,
	output logic mem_read,
	output logic [ssl_pkg::LINE_W-1:0] mem_writedata,
	input wire logic [ssl_pkg::LINE_W-1:0] mem_readdata,
	input wire logic mem_waitrequest,
	// Architectural state
	input wire ssl_pkg::ssl_arch_s arch_i,
	output var ssl_pkg::ssl_arch_s rest_o,
	output logic rest_valid,
	output logic [2:0] rest_comp,
	// Status
	output logic busy,
	output logic gp_fault,
	output logic ud_fault,
	output logic wide_vec_usable
);
	import ssl_pkg::*;

	logic wait_q;
	logic [31:0] rdata_q;
	logic save_en_q, mode64_q, pfx64_q, seldep_q;
	logic [2:0] fec_q;
	logic [63:0] cbm_q;
	logic [ADDR_W-1:0] base_q;
	logic [2:0] mask_q;
	logic done_q, gp_q, ud_q, wvu_q, busy_q, rvalid_q, restore_q, abort_q;
	logic [2:0] rcomp_q;
	logic [7:0] ftag_q;
	ssl_state_e state_q, state_d;
	logic [5:0] step_q, step_d;
	ssl_mem_req_s mem_q, mem_d;
	ssl_arch_s rest_q;

	// Bus decode: every access waits exactly one cycle, which keeps read data registered.
	wire logic acc = (avs_read | avs_write) & wait_q;
	wire logic wr_fire = avs_write & ~wait_q;
	wire logic [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	function automatic logic [31:0] merge(input logic [31:0] old);
		return (old & ~be_mask) | (avs_writedata & be_mask);
	endfunction
	wire logic wr_ctrl = wr_fire & (avs_address == REG_CTRL);
	wire logic wr_fec = wr_fire & (avs_address == REG_FEC);
	wire logic wr_stat = wr_fire & (avs_address == REG_STATUS);
	wire logic [31:0] ctrl_cur = {28'h0, seldep_q, pfx64_q, mode64_q, save_en_q};
	wire logic [31:0] ctrl_new = merge(ctrl_cur);
	wire logic [31:0] fec_new = merge({29'h0, fec_q});
	wire logic [31:0] mask_new = merge({29'h0, mask_q});
	wire logic fec_bad = wr_fec & fec_new[2] & ~fec_new[1];
	wire logic [31:0] stat_cur = {27'h0, wvu_q, ud_q, gp_q, done_q, busy_q};
	wire logic [31:0] stat_clr = avs_writedata & be_mask & {32{wr_stat}};

	wire logic idle = state_q == S_IDLE;
	wire logic go_save = wr_ctrl & ctrl_new[CTRL_GO_SAVE] & idle;
	wire logic go_rest = wr_ctrl & ctrl_new[CTRL_GO_REST] & idle & ~go_save;
	// The enable bit written with the start bit decides, so one write may enable and start.
	wire logic start_ok = (go_save | go_rest) & ctrl_new[0];
	wire logic start_ud = (go_save | go_rest) & ~ctrl_new[0];

	// Requested components; component 2 needs both enables and, compacted, its bitmap bit.
	wire logic [2:0] rfbm = {fec_q[2] & fec_q[1], fec_q[1], fec_q[0]}
		& mask_q & {3{save_en_q}};
	wire logic compacted = cbm_q[FMT_BIT];
	wire logic comp2_here = rfbm[2] & (~compacted | cbm_q[FIRST_EXT]);

	// Enumeration table: component 2 is the only extended component implemented.
	wire logic [N_COMP-1:0][15:0] tab_size = {COMP2_SIZE, 16'h0000, 16'h0000};
	wire logic [N_COMP-1:0][15:0] tab_off = {EXT_OFF, 16'h0000, 16'h0000};
	logic [N_COMP-1:0][15:0] comp_off;
	logic [15:0] area_end;
	ssl_offset_calc #(
		.N_COMP(N_COMP)
	) u_off (
		.bitmap(cbm_q[N_COMP-1:0]),
		.compacted(compacted),
		.size(tab_size),
		.std_off(tab_off),
		.comp_off(comp_off),
		.area_end(area_end)
	);

	logic [7:0] abr_save;
	logic [15:0] ftw_rest;
	ssl_tag_abridge u_tag (
		.ftw_full(arch_i.fp_tag_word),
		.abr_out(abr_save),
		.abr_in(ftag_q),
		.st(rest_q.st),
		.ftw_out(ftw_rest)
	);

	// Line classification of the current step.
	wire logic in_l0 = step_q == LINE_HDR0;
	wire logic in_l1 = step_q == LINE_HDR1;
	wire logic in_st = (step_q >= LINE_ST) && (step_q < LINE_XMM);
	wire logic in_xmm = (step_q >= LINE_XMM) && (step_q < LINE_C2);
	wire logic xmm_hi = step_q >= LINE_XMM_HI;
	wire logic in_c2 = step_q >= LINE_C2;
	wire logic c2_hi = step_q >= LINE_C2_HI;
	wire logic [5:0] rel = in_c2 ? step_q - LINE_C2 : in_xmm ? step_q - LINE_XMM : step_q - LINE_ST;
	wire logic [3:0] idx = rel[3:0];
	// Upper vector halves are never touched outside 64-bit mode, neither read nor written.
	wire logic line_en = in_l0 ? rfbm[0] : in_l1 ? |rfbm : in_st ? rfbm[0] :
		in_xmm ? rfbm[1] & (~xmm_hi | mode64_q) :
		comp2_here & (~c2_hi | mode64_q);
	wire logic [ADDR_W-1:0] line_off = in_c2 ?
		ADDR_W'(comp_off[FIRST_EXT]) + (ADDR_W'(rel) << LINE_SHIFT) :
		ADDR_W'(step_q) << LINE_SHIFT;

	// Save data: line 0 and line 1 packing.
	wire logic [15:0] fcs_s = seldep_q ? SEL_ZERO : arch_i.fcs;
	wire logic [15:0] fds_s = seldep_q ? SEL_ZERO : arch_i.fds;
	wire logic [63:0] fip_s = pfx64_q ? arch_i.fp_instr_pointer : {16'h0, fcs_s, arch_i.fp_instr_pointer[31:0]};
	wire logic [63:0] fdp_s = pfx64_q ? arch_i.fp_data_pointer : {16'h0, fds_s, arch_i.fp_data_pointer[31:0]};
	wire logic [LINE_W-1:0] l0_s = {fip_s, arch_i.fp_last_opcode, 8'h00, abr_save,
		arch_i.fp_status_word, arch_i.fp_control_word};
	wire logic [LINE_W-1:0] l1_s = {VECTOR_CONTROL_STATUS_VALID, arch_i.vector_control_status, fdp_s};
	wire logic [LINE_W-1:0] st_s = {{(LINE_W-FP_W){1'b0}}, arch_i.st[idx[2:0]]};
	wire logic [LINE_W-1:0] save_line = in_l0 ? l0_s : in_l1 ? l1_s : in_st ? st_s :
		in_xmm ? arch_i.xmm[idx] : arch_i.ymmh[idx];

	wire logic mem_done = (state_q == S_XFER) & ~mem_waitrequest;
	wire logic mx_bad = mem_done & restore_q & in_l1 &
		(|(mem_readdata[L1_VECTOR_CONTROL_STATUS +: 32] & ~VECTOR_CONTROL_STATUS_VALID));
	wire logic rd_take = mem_done & restore_q & ~mx_bad;
	wire logic commit = (state_q == S_DONE) & restore_q & ~abort_q;
	wire logic keep_sel = ~pfx64_q & ~seldep_q;

	wire logic [31:0] rd_mux =
		(avs_address == REG_CTRL) ? ctrl_cur :
		(avs_address == REG_FEC) ? {29'h0, fec_q} :
		(avs_address == REG_CBM_LO) ? cbm_q[31:0] :
		(avs_address == REG_CBM_HI) ? cbm_q[63:32] :
		(avs_address == REG_BASE) ? base_q :
		(avs_address == REG_MASK) ? {29'h0, mask_q} :
		(avs_address == REG_STATUS) ? stat_cur :
		(avs_address == REG_C2_OFF) ? {16'h0, comp_off[FIRST_EXT]} :
		(avs_address == REG_AREA_END) ? {16'h0, area_end} : 32'h0;

	always_comb begin
		state_d = state_q;
		step_d = step_q;
		mem_d = mem_q;
		unique case (state_q)
			S_IDLE: begin
				if (start_ok) begin
					state_d = S_SCAN;
					step_d = LINE_HDR0;
				end
			end
			S_SCAN: begin
				if (line_en) begin
					mem_d.addr = base_q + line_off;
					mem_d.write = ~restore_q;
					mem_d.read = restore_q;
					mem_d.wdata = restore_q ? '0 : save_line;
					state_d = S_XFER;
				end else if (step_q == LINE_LAST) begin
					state_d = S_DONE;
				end else begin
					step_d = step_q + 6'h01;
				end
			end
			S_XFER: begin
				if (!mem_waitrequest) begin
					mem_d.write = 1'b0;
					mem_d.read = 1'b0;
					if (mx_bad || step_q == LINE_LAST) begin
						state_d = S_DONE;
					end else begin
						state_d = S_SCAN;
						step_d = step_q + 6'h01;
					end
				end
			end
			S_DONE: begin
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wait_q <= 1'b1;
			rdata_q <= '0;
		end else begin
			wait_q <= ~acc;
			if (acc && avs_read) begin
				rdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			{seldep_q, pfx64_q, mode64_q, save_en_q} <= '0;
			fec_q <= FEC_RESET;
			cbm_q <= '0;
			base_q <= '0;
			mask_q <= '0;
		end else if (wr_fire) begin
			if (wr_ctrl) begin
				{seldep_q, pfx64_q, mode64_q, save_en_q} <= ctrl_new[3:0];
			end
			if (wr_fec && !fec_bad) begin
				fec_q <= fec_new[2:0] | FEC_RESET;
			end
			if (avs_address == REG_CBM_LO) begin
				cbm_q[31:0] <= merge(cbm_q[31:0]);
			end
			if (avs_address == REG_CBM_HI) begin
				cbm_q[63:32] <= merge(cbm_q[63:32]);
			end
			if (avs_address == REG_BASE) begin
				base_q <= merge(base_q) & ~ALIGN_MASK;
			end
			if (avs_address == REG_MASK) begin
				mask_q <= mask_new[2:0];
			end
		end
	end

	// Hardware sets win over a same-cycle write-one-to-clear.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			done_q <= 1'b0;
			gp_q <= 1'b0;
			ud_q <= 1'b0;
			wvu_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			done_q <= (state_q == S_DONE) | (done_q & ~stat_clr[STAT_DONE]);
			gp_q <= fec_bad | mx_bad | (gp_q & ~stat_clr[STAT_GP]);
			ud_q <= start_ud | (ud_q & ~stat_clr[STAT_UD]);
			wvu_q <= save_en_q & fec_q[1] & fec_q[2];
			busy_q <= state_d != S_IDLE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= S_IDLE;
			step_q <= LINE_HDR0;
			mem_q <= '0;
			restore_q <= 1'b0;
			abort_q <= 1'b0;
			rvalid_q <= 1'b0;
			rcomp_q <= '0;
		end else begin
			state_q <= state_d;
			step_q <= step_d;
			mem_q <= mem_d;
			rvalid_q <= commit;
			if (start_ok) begin
				restore_q <= go_rest;
				abort_q <= 1'b0;
			end else if (mx_bad) begin
				abort_q <= 1'b1;
			end
			if (commit) begin
				rcomp_q <= {comp2_here, rfbm[1:0]};
			end
		end
	end

	// Restore staging starts from the live state so skipped fields keep their values.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rest_q <= '0;
			ftag_q <= '0;
		end else if (start_ok && go_rest) begin
			rest_q <= arch_i;
			ftag_q <= abr_save;
		end else if (rd_take && in_l0) begin
			rest_q.fp_control_word <= mem_readdata[L0_FCW +: 16];
			rest_q.fp_status_word <= mem_readdata[L0_FSW +: 16];
			rest_q.fp_last_opcode <= mem_readdata[L0_FOP +: 16];
			ftag_q <= mem_readdata[L0_FTAG +: 8];
			rest_q.fp_instr_pointer <= pfx64_q ? mem_readdata[L0_FIP +: 64] :
				64'(mem_readdata[L0_FIP +: 32]);
			if (keep_sel) begin
				rest_q.fcs <= mem_readdata[L0_FCS +: 16];
			end
		end else if (rd_take && in_l1) begin
			// The mask word in bytes 31:28 is never loaded.
			rest_q.fp_data_pointer <= pfx64_q ? mem_readdata[L1_FDP +: 64] :
				64'(mem_readdata[L1_FDP +: 32]);
			rest_q.vector_control_status <= mem_readdata[L1_VECTOR_CONTROL_STATUS +: 32];
			if (keep_sel) begin
				rest_q.fds <= mem_readdata[L1_FDS +: 16];
			end
		end else if (rd_take && in_st) begin
			rest_q.st[idx[2:0]] <= mem_readdata[FP_W-1:0];
		end else if (rd_take && in_xmm) begin
			rest_q.xmm[idx] <= mem_readdata;
		end else if (rd_take) begin
			rest_q.ymmh[idx] <= mem_readdata;
		end else if (commit && rfbm[0]) begin
			rest_q.fp_tag_word <= ftw_rest;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign mem_address = mem_q.addr;
	assign mem_write = mem_q.write;
	assign mem_read = mem_q.read;
	assign mem_writedata = mem_q.wdata;
	assign rest_o = rest_q;
	assign rest_valid = rvalid_q;
	assign rest_comp = rcomp_q;
	assign busy = busy_q;
	assign gp_fault = gp_q;
	assign ud_fault = ud_q;
	assign wide_vec_usable = wvu_q;
endmodule
`default_nettype wire

// [ssl_pkg.sv]
package ssl_pkg;
	localparam int ADDR_W = 32;
	localparam int LINE_W = 128;
	localparam int LINE_SHIFT = 4;
	localparam int N_COMP = 3;
	localparam int FIRST_EXT = 2;
	localparam int FMT_BIT = 63;
	localparam int FP_W = 80;
	localparam int FP_EXP_LSB = 64;
	localparam int FP_EXP_W = 15;
	localparam int FP_INT_BIT = 63;
	localparam logic [15:0] HDR_OFF = 16'h0200;
	localparam logic [15:0] HDR_BYTES = 16'h0040;
	localparam logic [15:0] EXT_OFF = HDR_OFF + HDR_BYTES;
	localparam logic [15:0] COMP2_SIZE = 16'h0100;
	localparam logic [31:0] ALIGN_MASK = 32'h0000003f;
	// Bit positions inside save-area line 0 (bytes 15:0) and line 1 (bytes 31:16).
	localparam int L0_FCW = 0;
	localparam int L0_FSW = 16;
	localparam int L0_FTAG = 32;
	localparam int L0_FOP = 48;
	localparam int L0_FIP = 64;
	localparam int L0_FCS = 96;
	localparam int L1_FDP = 0;
	localparam int L1_FDS = 32;
	localparam int L1_VECTOR_CONTROL_STATUS = 64;
	localparam int L1_MASK = 96;
	// Line numbers of the transfer walk; component 2 lines follow the legacy lines.
	localparam logic [5:0] LINE_HDR0 = 6'h00;
	localparam logic [5:0] LINE_HDR1 = 6'h01;
	localparam logic [5:0] LINE_ST = 6'h02;
	localparam logic [5:0] LINE_XMM = 6'h0a;
	localparam logic [5:0] LINE_XMM_HI = 6'h12;
	localparam logic [5:0] LINE_C2 = 6'h1a;
	localparam logic [5:0] LINE_C2_HI = 6'h22;
	localparam logic [5:0] LINE_LAST = 6'h29;
	localparam logic [15:0] SEL_ZERO = 16'h0000;
	localparam logic [1:0] TAG_VALID = 2'b00;
	localparam logic [1:0] TAG_ZERO = 2'b01;
	localparam logic [1:0] TAG_SPECIAL = 2'b10;
	localparam logic [1:0] TAG_EMPTY = 2'b11;
	localparam logic [31:0] VECTOR_CONTROL_STATUS_VALID = 32'h0000ffff;
	localparam logic [2:0] FEC_RESET = 3'h1;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FEC = 8'h04;
	localparam logic [7:0] REG_CBM_LO = 8'h08;
	localparam logic [7:0] REG_CBM_HI = 8'h0c;
	localparam logic [7:0] REG_BASE = 8'h10;
	localparam logic [7:0] REG_MASK = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_C2_OFF = 8'h1c;
	localparam logic [7:0] REG_AREA_END = 8'h20;
	localparam int CTRL_GO_SAVE = 4;
	localparam int CTRL_GO_REST = 5;
	localparam int STAT_DONE = 1;
	localparam int STAT_GP = 2;
	localparam int STAT_UD = 3;
	typedef struct packed {
		logic [15:0] fp_control_word;
		logic [15:0] fp_status_word;
		logic [15:0] fp_last_opcode;
		logic [15:0] fp_tag_word;
		logic [63:0] fp_instr_pointer;
		logic [63:0] fp_data_pointer;
		logic [15:0] fcs;
		logic [15:0] fds;
		logic [31:0] vector_control_status;
		logic [7:0][FP_W-1:0] st;
		logic [15:0][LINE_W-1:0] xmm;
		logic [15:0][LINE_W-1:0] ymmh;
	} ssl_arch_s;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic write;
		logic read;
		logic [LINE_W-1:0] wdata;
	} ssl_mem_req_s;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_SCAN = 2'b01,
		S_XFER = 2'b10,
		S_DONE = 2'b11
	} ssl_state_e;
endpackage

// [ssl_offset_calc.sv]
`timescale 1ns/1ps
`default_nettype none
module ssl_offset_calc #(
	parameter int N_COMP = ssl_pkg::N_COMP
) (
	// Format selection
	input wire logic [N_COMP-1:0] bitmap,
	input wire logic compacted,
	// Enumerated table
	input wire logic [N_COMP-1:0][15:0] size,
	input wire logic [N_COMP-1:0][15:0] std_off,
	// Placement
	output logic [N_COMP-1:0][15:0] comp_off,
	output logic [15:0] area_end
);
	import ssl_pkg::*;
	logic [N_COMP-1:0][15:0] run_end;
	// The chain is purely combinational so every address is settled before a walk starts.
	for (genvar i = 0; i < N_COMP; i++) begin : g_comp
		if (i < FIRST_EXT) begin : g_legacy
			assign run_end[i] = EXT_OFF;
			assign comp_off[i] = '0;
		end else begin : g_ext
			wire logic [15:0] start = run_end[i-1];
			assign run_end[i] = start + (bitmap[i] ? size[i] : 16'h0000);
			assign comp_off[i] = compacted ? start : std_off[i];
		end
	end
	assign area_end = compacted ? run_end[N_COMP-1] : std_off[N_COMP-1] + size[N_COMP-1];
endmodule
`default_nettype wire

// [ssl_tag_abridge.sv]
`timescale 1ns/1ps
`default_nettype none
module ssl_tag_abridge (
	// Save direction
	input wire logic [15:0] ftw_full,
	output logic [7:0] abr_out,
	// Restore direction
	input wire logic [7:0] abr_in,
	input wire logic [7:0][ssl_pkg::FP_W-1:0] st,
	output logic [15:0] ftw_out
);
	import ssl_pkg::*;
	for (genvar j = 0; j < 8; j++) begin : g_reg
		wire logic [FP_EXP_W-1:0] exp = st[j][FP_EXP_LSB +: FP_EXP_W];
		wire logic [FP_EXP_LSB-1:0] man = st[j][FP_EXP_LSB-1:0];
		wire logic is_zero = (exp == '0) && (man == '0);
		wire logic is_spec = (&exp) || (exp == '0) || !man[FP_INT_BIT];
		wire logic [1:0] derived = is_zero ? TAG_ZERO : is_spec ? TAG_SPECIAL : TAG_VALID;
		assign abr_out[j] = ftw_full[2*j +: 2] != TAG_EMPTY;
		assign ftw_out[2*j +: 2] = abr_in[j] ? derived : TAG_EMPTY;
	end
endmodule
`default_nettype wire

// [ssl_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ssl_mem_model (
	// Clock, reset and answer delay
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] lat,
	// Line slave
	input wire logic [31:0] mem_address,
	input wire logic mem_write,
	input wire logic mem_read,
	input wire logic [127:0] mem_writedata,
	output logic [127:0] mem_readdata,
	output logic mem_waitrequest
);
	logic [127:0] mem [0:255];
	logic [3:0] cnt_q;
	logic req;
	assign req = mem_write || mem_read;
	assign mem_waitrequest = !(req && cnt_q == lat);
	// Outside the accepting cycle the data lines show garbage, never the stored line.
	assign mem_readdata = (mem_read && !mem_waitrequest) ? mem[mem_address[11:4]] :
		~mem[mem_address[11:4]];
	always @(posedge sys_clk) begin
		if (rst || !req || !mem_waitrequest) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
		if (mem_write && !mem_waitrequest) begin
			mem[mem_address[11:4]] <= mem_writedata;
		end
	end
endmodule
`default_nettype wire

// [ssl_layout_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ssl_layout_properties
	import ssl_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	// Line master
	input wire logic [ssl_pkg::ADDR_W-1:0] mem_address,
	input wire logic mem_write,
	input wire logic mem_read,
	input wire logic [ssl_pkg::LINE_W-1:0] mem_writedata,
	// State and status
	input wire ssl_pkg::ssl_arch_s arch_i,
	input wire logic busy,
	input wire logic gp_fault,
	input wire logic ud_fault
);
	logic [31:0] base_q, ctrl_q, off;
	logic [7:0] abr;
	logic [2:0] st_idx;
	logic acc, wr0, wr1;
	assign acc = avs_write && !avs_waitrequest;
	assign off = mem_address - base_q;
	assign st_idx = off[6:4] - 3'h2;
	assign wr0 = mem_write && off == 32'h00000000;
	assign wr1 = mem_write && off == 32'h00000010;
	always_comb begin
		for (int j = 0; j < 8; j++) begin
			abr[j] = arch_i.fp_tag_word[2*j +: 2] != TAG_EMPTY;
		end
	end
	// Shadow copies of what software wrote, so line contents can be judged.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			base_q <= 32'h00000000;
			ctrl_q <= 32'h00000000;
		end else if (acc && avs_address == REG_BASE) begin
			base_q <= avs_writedata & ~ALIGN_MASK;
		end else if (acc && avs_address == REG_CTRL) begin
			ctrl_q <= avs_writedata;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_fec_bad;
		acc && avs_address == REG_FEC && avs_writedata[2:1] == 2'b10;
	endsequence
	sequence s_go_off;
		acc && avs_address == REG_CTRL && avs_writedata[CTRL_GO_SAVE] && !avs_writedata[0] && !busy;
	endsequence
	a_head_fields: assert property (wr0 |-> mem_writedata[31:0] == {arch_i.fp_status_word, arch_i.fp_control_word}
		&& mem_writedata[63:48] == arch_i.fp_last_opcode && mem_writedata[39:32] == abr)
		else $error("line 0 control fields wrong");
	a_ptr_split: assert property (wr0 && !ctrl_q[2] |-> mem_writedata[127:64] ==
		{16'h0000, ctrl_q[3] ? SEL_ZERO : arch_i.fcs, arch_i.fp_instr_pointer[31:0]})
		else $error("split instruction pointer wrong");
	a_ptr_wide: assert property (wr0 && ctrl_q[2] |-> mem_writedata[127:64] == arch_i.fp_instr_pointer)
		else $error("wide instruction pointer wrong");
	a_data_split: assert property (wr1 && !ctrl_q[2] |-> mem_writedata[63:0] ==
		{16'h0000, ctrl_q[3] ? SEL_ZERO : arch_i.fds, arch_i.fp_data_pointer[31:0]})
		else $error("split data pointer wrong");
	a_data_wide: assert property (wr1 && ctrl_q[2] |-> mem_writedata[63:0] == arch_i.fp_data_pointer)
		else $error("wide data pointer wrong");
	a_vec_ctrl: assert property (wr1 |-> mem_writedata[127:64] == {VECTOR_CONTROL_STATUS_VALID, arch_i.vector_control_status})
		else $error("vector control fields wrong");
	a_st_slot: assert property (mem_write && off >= 32'd32 && off < 32'd160
		|-> mem_writedata[79:0] == arch_i.st[st_idx])
		else $error("stack register slot wrong");
	a_upper_xmm: assert property ((mem_write || mem_read) && off >= 32'd288 && off < 32'd416
		|-> ctrl_q[1])
		else $error("upper vector block touched outside 64-bit mode");
	a_upper_c2: assert property ((mem_write || mem_read) && off >= 32'd704 && off < 32'd832
		|-> ctrl_q[1])
		else $error("upper half block touched outside 64-bit mode");
	a_area_bound: assert property ((mem_write || mem_read) |-> mem_address[3:0] == 4'h0
		&& off < 32'd832)
		else $error("line address outside the save area");
	a_fec_reject: assert property (s_fec_bad |-> ##[1:2] gp_fault)
		else $error("bad enable write not faulted");
	a_go_ud: assert property (s_go_off |-> ##[1:3] ud_fault)
		else $error("start without save enable not faulted");
endmodule
bind ssl_layout ssl_layout_properties u_props (.sys_clk, .rst, .avs_address, .avs_write,
	.avs_writedata, .avs_waitrequest, .mem_address, .mem_write, .mem_read, .mem_writedata,
	.arch_i, .busy, .gp_fault, .ud_fault);
`default_nettype wire

// [ssl_layout_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ssl_layout_tb;
	import ssl_pkg::*;
	localparam logic [31:0] BASE = 32'h00000040;
	localparam logic [127:0] PAT = {4{32'h5a5aa5a5}};
	logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, mem_write, mem_read;
	logic mem_waitrequest, rest_valid, busy, gp_fault, ud_fault, wide_vec_usable;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, mem_address, q;
	logic [127:0] mem_writedata, mem_readdata, t;
	logic [3:0] lat;
	logic [2:0] rest_comp;
	ssl_arch_s arch, rest_o;
	int err_total, total_checks, rv_cnt, cyc;
	ssl_layout uut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .mem_address, .mem_write,
		.mem_read, .mem_writedata, .mem_readdata, .mem_waitrequest, .arch_i(arch), .rest_o,
		.rest_valid, .rest_comp, .busy, .gp_fault, .ud_fault, .wide_vec_usable);
	ssl_mem_model mdl (.sys_clk, .rst, .lat, .mem_address, .mem_write, .mem_read,
		.mem_writedata, .mem_readdata, .mem_waitrequest);
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (rest_valid === 1'b1) rv_cnt++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	function automatic logic [127:0] ln(input logic [31:0] off);
		return mdl.mem[8'((BASE + off) >> 4)];
	endfunction
	task automatic run(input logic [31:0] c);
		bus(1'b1, REG_CTRL, c);
		repeat (2) @(posedge sys_clk);
		while (busy !== 1'b0) @(posedge sys_clk);
		@(posedge sys_clk);
	endtask
	task automatic t_enable();
		bus(1'b0, REG_FEC, 32'h0);
		chk(q, 32'h1);
		bus(1'b1, REG_FEC, 32'h4);
		@(posedge sys_clk);
		chk(gp_fault, 1'b1);
		bus(1'b0, REG_FEC, 32'h0);
		chk(q, 32'h1);
		bus(1'b1, REG_FEC, 32'h0);
		bus(1'b0, REG_FEC, 32'h0);
		chk(q, 32'h1);
		bus(1'b1, REG_STATUS, 32'hc);
		bus(1'b1, REG_FEC, 32'h7);
		bus(1'b1, REG_CTRL, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk(wide_vec_usable, 1'b1);
		bus(1'b1, REG_FEC, 32'h3);
		repeat (2) @(posedge sys_clk);
		chk(wide_vec_usable, 1'b0);
		bus(1'b1, REG_FEC, 32'h7);
	endtask
	task automatic t_area();
		bus(1'b1, REG_CBM_HI, 32'h0);
		bus(1'b0, REG_C2_OFF, 32'h0);
		chk(q, 32'h00000240);
		bus(1'b0, REG_AREA_END, 32'h0);
		chk(q, 32'h00000340);
		bus(1'b1, REG_CBM_HI, 32'h80000000);
		bus(1'b1, REG_CBM_LO, 32'h0);
		bus(1'b0, REG_AREA_END, 32'h0);
		chk(q, 32'h00000240);
		bus(1'b1, REG_CBM_LO, 32'h4);
		bus(1'b0, REG_C2_OFF, 32'h0);
		chk(q, 32'h00000240);
		bus(1'b0, REG_AREA_END, 32'h0);
		chk(q, 32'h00000340);
	endtask
	task automatic t_save64();
		lat <= 4'h1;
		bus(1'b1, REG_CBM_HI, 32'h0);
		bus(1'b1, REG_MASK, 32'h7);
		bus(1'b1, REG_BASE, BASE);
		run(32'h17);
		chk(ln(0), {arch.fp_instr_pointer, arch.fp_last_opcode, 16'h0081, arch.fp_status_word, arch.fp_control_word});
		chk(ln(16), {32'h0000ffff, arch.vector_control_status, arch.fp_data_pointer});
		t = ln(80);
		chk(t[79:0], arch.st[3]);
		chk(ln(400), arch.xmm[15]);
		chk(ln(816), arch.ymmh[15]);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(q[STAT_DONE], 1'b1);
	endtask
	task automatic t_save32();
		for (int i = 0; i < 256; i++) mdl.mem[i] = PAT;
		lat <= 4'h3;
		bus(1'b1, REG_CBM_HI, 32'h80000000);
		run(32'h19);
		t = ln(0);
		chk(t[127:64], {32'h0, arch.fp_instr_pointer[31:0]});
		t = ln(16);
		chk(t[63:0], {32'h0, arch.fp_data_pointer[31:0]});
		chk(ln(272), arch.xmm[7]);
		chk(ln(288), PAT);
		chk(ln(576), arch.ymmh[0]);
		chk(ln(704), PAT);
	endtask
	task automatic t_restore();
		lat <= 4'h0;
		mdl.mem[8'(BASE >> 4)] = {64'h0123456789abcdef, 64'h0000000300000000 | 64'h037f};
		mdl.mem[8'(BASE >> 4) + 8'h1] = {32'hdeadbeef, 32'h00010000, 64'h0};
		mdl.mem[8'(BASE >> 4) + 8'h2] = {48'h0, 80'h3fff8000000000000000};
		mdl.mem[8'(BASE >> 4) + 8'h3] = 128'h0;
		run(32'h27);
		chk(gp_fault, 1'b1);
		chk(rv_cnt, 0);
		bus(1'b1, REG_STATUS, 32'h4);
		mdl.mem[8'(BASE >> 4) + 8'h1] = {32'hdeadbeef, 32'h00001f80, 64'h0};
		run(32'h27);
		chk(rv_cnt, 1);
		chk(rest_comp, 3'b111);
		chk(rest_o.vector_control_status, 32'h00001f80);
		chk(rest_o.fp_tag_word, 16'hfff4);
		chk(rest_o.st[0], 80'h3fff8000000000000000);
		chk(rest_o.fp_instr_pointer, 64'h0123456789abcdef);
	endtask
	task automatic t_unusable();
		bus(1'b1, REG_CTRL, 32'h10);
		repeat (3) @(posedge sys_clk);
		chk(ud_fault, 1'b1);
	endtask
	initial begin
		rst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata, err_total, total_checks, rv_cnt} = '0;
		cyc = 0;
		lat = 4'h1;
		arch = '0;
		arch.fp_control_word = 16'h037f;
		arch.fp_status_word = 16'h1234;
		arch.fp_last_opcode = 16'h0abc;
		arch.fp_tag_word = 16'h3ffc;
		arch.fp_instr_pointer = 64'h1122334455667788;
		arch.fp_data_pointer = 64'h99aabbccddeeff00;
		arch.fcs = 16'h0023;
		arch.fds = 16'h002b;
		arch.vector_control_status = 32'h00001f80;
		for (int i = 0; i < 16; i++) begin
			arch.xmm[i] = {8{16'h1000 + 16'(i)}};
			arch.ymmh[i] = {8{16'h2000 + 16'(i)}};
			if (i < 8) arch.st[i] = {16'h4000 + 16'(i), 64'h8000000000000000};
		end
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_enable();
		t_area();
		t_save64();
		t_save32();
		t_restore();
		t_unusable();
		results();
	end
endmodule
`default_nettype wire
